// ==== design/instr_clock_gen.sv ====
// Instruction clock tick generator, one pulse every four system clocks
`default_nettype none
module instr_clock_gen (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Tick out
  output logic tick
);
  import period_timer_pkg::*;

  typedef struct packed {
    logic [1:0] phase;
  } gen_state_t;

  gen_state_t st_r;
  gen_state_t st_nxt;

  // Free running quarter-rate phase counter
  always_comb begin
    st_nxt = st_r;
    st_nxt.phase = st_r.phase + 2'h1;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = (st_r.phase == INSTR_DIV);
endmodule
`default_nettype wire

// ==== design/period_timer.sv ====
// Period timer with prescaler, period match and postscaler
//
// The address map and the plain strobed port were decided locally.
`default_nettype none
module period_timer (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Interrupt
  output logic irq
);
  import period_timer_pkg::*;

  typedef struct packed {
    logic [7:0] control;
    logic [7:0] period;
    logic [7:0] count;
    logic [3:0] pre_cnt;
    logic [3:0] post_cnt;
    logic flag;
    logic mask;
    logic [7:0] rdata;
  } timer_state_t;

  timer_state_t st_r;
  timer_state_t st_nxt;
  logic instr_tick;
  logic [3:0] pre_limit;
  logic pre_pulse;
  logic match;
  logic post_event;

  // Prescale division from the select code, less one
  function automatic logic [3:0] pre_last(input logic [1:0] sel);
    if (sel[1]) begin
      pre_last = PRE_DIV16;
    end else if (sel[0]) begin
      pre_last = PRE_DIV4;
    end else begin
      pre_last = 4'h0;
    end
  endfunction

  instr_clock_gen u_tick (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(instr_tick)
  );

  assign pre_limit = pre_last(st_r.control[PRE_LSB +: 2]);
  assign pre_pulse = instr_tick && st_r.control[ON_BIT] &&
                     (st_r.pre_cnt == pre_limit);
  assign match = (st_r.count == st_r.period);
  // Postscaler fires when its counter reaches the selected code
  assign post_event = pre_pulse && match &&
                      (st_r.post_cnt == st_r.control[POST_LSB +: 4]);

  // Next state: counting, register writes, flag and read data
  always_comb begin
    st_nxt = st_r;
    // Prescaler only moves while on; the control write that stops it also clears its phase
    if (instr_tick && st_r.control[ON_BIT]) begin
      if (st_r.pre_cnt == pre_limit) begin
        st_nxt.pre_cnt = 4'h0;
      end else begin
        st_nxt.pre_cnt = st_r.pre_cnt + 4'h1;
      end
    end
    if (pre_pulse) begin
      if (match) begin
        st_nxt.count = 8'h00;
        // Each match advances the postscaler
        if (post_event) begin
          st_nxt.post_cnt = 4'h0;
        end else begin
          st_nxt.post_cnt = st_r.post_cnt + 4'h1;
        end
      end else begin
        st_nxt.count = st_r.count + 8'h01;
      end
    end
    // Software writes take priority over counting
    if (reg_wr) begin
      case (reg_addr)
        ADDR_CONTROL: begin
          st_nxt.control = reg_wdata & CONTROL_WMASK;
          st_nxt.count = st_r.count;
          st_nxt.pre_cnt = 4'h0;
          st_nxt.post_cnt = 4'h0;
        end
        ADDR_PERIOD: begin
          st_nxt.period = reg_wdata;
        end
        ADDR_COUNT: begin
          st_nxt.count = reg_wdata;
          st_nxt.pre_cnt = 4'h0;
          st_nxt.post_cnt = 4'h0;
        end
        ADDR_FLAGS: begin
          // Write one clears; a simultaneous event still wins below
          if (reg_wdata[FLAG_BIT]) begin
            st_nxt.flag = 1'b0;
          end
        end
        ADDR_MASK: begin
          st_nxt.mask = reg_wdata[FLAG_BIT];
        end
        default: begin
        end
      endcase
    end
    // Event set beats clear, and a set flag stays set
    if (post_event && !(reg_wr && reg_addr == ADDR_CONTROL) &&
        !(reg_wr && reg_addr == ADDR_COUNT)) begin
      st_nxt.flag = 1'b1;
    end
    // Read data registered, valid the cycle after the strobe
    st_nxt.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CONTROL: st_nxt.rdata = st_r.control & CONTROL_WMASK;
        ADDR_PERIOD: st_nxt.rdata = st_r.period;
        ADDR_COUNT: st_nxt.rdata = st_r.count;
        ADDR_FLAGS: st_nxt.rdata = {6'h00, st_r.flag, 1'b0};
        ADDR_MASK: st_nxt.rdata = {6'h00, st_r.mask, 1'b0};
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  // State register with synchronous reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r.control <= CONTROL_RST;
      st_r.period <= PERIOD_RST;
      st_r.count <= COUNT_RST;
      st_r.pre_cnt <= 4'h0;
      st_r.post_cnt <= 4'h0;
      st_r.flag <= 1'b0;
      st_r.mask <= 1'b0;
      st_r.rdata <= 8'h00;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign irq = st_r.flag & st_r.mask;
endmodule
`default_nettype wire

// ==== design/period_timer_pkg.sv ====
// Constants shared by the period timer design
// Functional notes
// - The timer ticks from the instruction clock, one pulse every four system clocks, into the prescaler.
// - Prescale select 00 divides by 1, 01 by 4, and 1x by 16.
// - Each prescaler pulse increments the 8-bit count from zero, always compared with the period.
// - When count equals period, the next increment returns the count to zero.
// - Every count/period match advances the postscaler by one.
// - Postscale select in control bits 6..3 gives ratio code+1, from 1:1 to 1:16.
// - Each postscaler output event sets the period event flag in the peripheral flag register; here a same-cycle control or count write blocks the set.
// - Any reset loads count with 00h and period with FFh.
// - Count and period registers are fully readable and writable at any time.
// - The timer runs only while the timer_on bit (control bit 2) is one.
// - Prescaler and postscaler counters clear on a count write, a control write, or any reset.
// - A control write leaves the count value unchanged.
// - Control bit 7 is unimplemented and reads as zero.
`default_nettype none
package period_timer_pkg;
  // Register addresses (word index on the register port)
  localparam logic [2:0] ADDR_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_PERIOD = 3'h1;
  localparam logic [2:0] ADDR_COUNT = 3'h2;
  localparam logic [2:0] ADDR_FLAGS = 3'h3;
  localparam logic [2:0] ADDR_MASK = 3'h4;
  // Control field positions, and the flag bit in the flag and mask registers
  localparam int PRE_LSB = 0;
  localparam int ON_BIT = 2;
  localparam int POST_LSB = 3;
  localparam int FLAG_BIT = 1;
  // Reset values and the control write mask
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'hFF;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] CONTROL_WMASK = 8'h7F;
  // Timing counts
  localparam logic [1:0] INSTR_DIV = 2'h3;
  localparam logic [3:0] PRE_DIV4 = 4'h3;
  localparam logic [3:0] PRE_DIV16 = 4'hF;
endpackage
`default_nettype wire

// ==== testbench/period_timer_checker.sv ====
// Assertions on the period timer register port and interrupt output
`default_nettype none
module period_timer_checker
  import period_timer_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Interrupt
  input wire logic irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Writes that may lower the interrupt, a registered irq may lag one cycle
  logic clr_w;
  assign clr_w = reg_wr && (reg_addr == ADDR_FLAGS || reg_addr == ADDR_MASK);
  // Write, one idle cycle, then read back the same register
  sequence wr_rd(logic [2:0] a);
    reg_wr && reg_addr == a ##1 !reg_wr ##1 reg_rd && reg_addr == a;
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> reg_rdata == 8'h00 && !irq)
    else $error("outputs active during reset");
  a_idle_data_zero: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data without a read");
  a_ctrl_top_zero: assert property (reg_rd && reg_addr == ADDR_CONTROL |=> !reg_rdata[7])
    else $error("control top bit not zero");
  a_period_rw: assert property (wr_rd(ADDR_PERIOD) |=> reg_rdata == $past(reg_wdata, 3))
    else $error("period read back differs");
  a_ctrl_rw: assert property (wr_rd(ADDR_CONTROL) |=> reg_rdata == {1'b0, $past(reg_wdata[6:0], 3)})
    else $error("control read back differs");
  a_unmapped_zero: assert property (reg_rd && reg_addr > ADDR_MASK |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_irq_fall_cause: assert property ($fell(irq) |-> $past(clr_w) || $past(clr_w, 2))
    else $error("interrupt dropped without a clear");
  a_mask_off: assert property (reg_wr && reg_addr == ADDR_MASK && !reg_wdata[FLAG_BIT] |-> ##2 !irq)
    else $error("interrupt high while masked");
endmodule
bind period_timer period_timer_checker period_timer_checker_inst (.mclk(mclk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .irq(irq));
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the period timer
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import period_timer_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, irq;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  int miscompares = 0, checked = 0, n;
  period_timer period_timer_inst (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  // 100 MHz clock
  initial begin
    forever #5 mclk = ~mclk;
  end
  task automatic conclude;
    if (miscompares == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(string w, logic [31:0] s, logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", w, e, s);
    end
  endtask
  // Bus cycles; strobes drop at the taking edge so tasks never collide
  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rc(string w, logic [2:0] a, logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    check(w, reg_rdata, e);
  endtask
  // Skip the first cycles so a lagging irq from before a clear is not taken
  task automatic wait_irq;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (!(irq === 1'b1 && n > 2) && n < 5000);
    if (n >= 5000) begin
      miscompares++;
      conclude();
    end
  endtask
  task automatic reset_values;
    rc("control", ADDR_CONTROL, CONTROL_RST);
    rc("period", ADDR_PERIOD, PERIOD_RST);
    rc("count", ADDR_COUNT, COUNT_RST);
    rc("flags", ADDR_FLAGS, 8'h00);
  endtask
  task automatic reg_access;
    wr(ADDR_PERIOD, 8'hA5);
    rc("period", ADDR_PERIOD, 8'hA5);
    wr(ADDR_CONTROL, 8'hFB);
    rc("control", ADDR_CONTROL, 8'h7B);
    wr(ADDR_COUNT, 8'h5A);
    wr(ADDR_CONTROL, 8'h78);
    repeat (40) @(posedge mclk);
    rc("count held", ADDR_COUNT, 8'h5A);
    rc("unmapped", 3'h7, 8'h00);
  endtask
  // Interval between two flag events, measured after the first settles
  task automatic period_run(logic [1:0] pre, logic [3:0] post, logic [7:0] per);
    int div;
    div = (pre == 2'h0) ? 1 : (pre == 2'h1) ? 4 : 16;
    wr(ADDR_PERIOD, per);
    // Restart the count so a value above the new period cannot force a long wrap
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_CONTROL, {1'b0, post, 1'b1, pre});
    wr(ADDR_FLAGS, 8'h02);
    wait_irq();
    wr(ADDR_FLAGS, 8'h02);
    wait_irq();
    check("interval", n + 1, 4 * div * (per + 1) * (post + 1));
  endtask
  task automatic flag_sticky;
    repeat (100) @(posedge mclk);
    rc("flag held", ADDR_FLAGS, 8'h02);
    check("irq", irq, 1'b1);
    wr(ADDR_MASK, 8'h00);
    rc("flag masked", ADDR_FLAGS, 8'h02);
    check("irq masked", irq, 1'b0);
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    reset_values();
    reg_access();
    wr(ADDR_MASK, 8'h02);
    period_run(2'h0, 4'h0, 8'h03);
    period_run(2'h1, 4'h2, 8'h02);
    period_run(2'h2, 4'hF, 8'h01);
    period_run(2'h3, 4'h1, 8'h00);
    flag_sticky();
    conclude();
  end
endmodule
`default_nettype wire
